// ### rtl/brownout_defines.svh
`ifndef BROWNOUT_DEFINES_SVH
`define BROWNOUT_DEFINES_SVH

// reference clock
`define CLK_FREQ_KHZ        125000

// line sag timing
`define BLANK_TIME_MS       500
`define BLANK_MIN_TIME_MS   380
`define WINDOW_TIME_MS      50
`define BLANK_CYCLES        (`BLANK_TIME_MS * `CLK_FREQ_KHZ)
`define BLANK_MIN_CYCLES    (`BLANK_MIN_TIME_MS * `CLK_FREQ_KHZ)
`define WINDOW_CYCLES       (`WINDOW_TIME_MS * `CLK_FREQ_KHZ)

// timing pin open detection, least time rounded up
`define TPIN_BLANK_TIME_US  30
`define TPIN_BLANK_CYCLES   ((`TPIN_BLANK_TIME_US * `CLK_FREQ_KHZ + 999) / 1000)
`define TPIN_CNT_W          12

// positions of the synchronised comparator flags
`define FLAG_SAG_COMP       0
`define FLAG_TIMING_LOW     1
`define FLAG_UNDERVOLT      2
`define FLAG_LATCH_OFF      3
`define FLAG_TEMP_HOT       4
`define FLAG_TEMP_COOL      5
`define FLAG_SUPPLY_START   6
`define FLAG_SUPPLY_STOP    7
`define FLAG_REG_REACHED    8
`define FLAG_COUNT          9

// reset values
`define SYNC_RST            1'b0
`define LOCKOUT_RST         1'b1
`define OVERTEMP_RST        1'b0
`define STARTUP_RST         1'b1
`define TPIN_OPEN_RST       1'b0

`endif

// ### rtl/brownout_pkg.sv
package brownout_pkg;
    `include "brownout_defines.svh"

    typedef enum logic [1:0]
    {
        SAG_IDLE,
        SAG_BLANK,
        SAG_WINDOW,
        SAG_FAULT
    } sag_state_t;

    typedef logic [`FLAG_COUNT-1:0] flag_vec_t;
endpackage

// ### rtl/flag_sync_if.sv
`timescale 1ns/10ps
interface flag_sync_if
#(
    parameter int unsigned WIDTH = 1
);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] synced;

    modport sync_side (input raw, output synced);
    modport user_side (output raw, input synced);
endinterface

// ### rtl/flag_sync.sv
`timescale 1ns/10ps
module flag_sync
    import brownout_pkg::*;
#(
    parameter int unsigned WIDTH = `FLAG_COUNT
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // flags in and out
    flag_sync_if.sync_side flags
);

    logic [WIDTH-1:0] stage1_q;
    logic [WIDTH-1:0] stage2_q;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    stage1_q[i] <= `SYNC_RST;
                    stage2_q[i] <= `SYNC_RST;
                end
                else
                begin
                    stage1_q[i] <= flags.raw[i];
                    stage2_q[i] <= stage1_q[i];
                end
            end
        end
    endgenerate

    assign flags.synced = stage2_q;

endmodule

// ### rtl/brownout_fault_sequencer.sv
`timescale 1ns/10ps
module brownout_fault_sequencer
    import brownout_pkg::*;
#(
    parameter int unsigned BLANK_CYCLES  = `BLANK_CYCLES,
    parameter int unsigned WINDOW_CYCLES = `WINDOW_CYCLES
)
(
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,

    // comparator flags
    input  wire logic line_sag_comparator_out,
    input  wire logic timing_current_low,
    input  wire logic output_undervoltage_protect,
    input  wire logic latch_off_request,
    input  wire logic temp_above_upper,
    input  wire logic temp_below_lower,
    input  wire logic supply_above_start,
    input  wire logic supply_below_stop,
    input  wire logic regulation_reached,

    // power stage controls
    output logic      gate_drive_a_en,
    output logic      gate_drive_b_en,
    output logic      control_node_ground,
    output logic      converter_ready,

    // line sense pin controls
    output logic      hold_clamp_switch,
    output logic      hysteresis_current_source,
    output logic      sense_pin_pulldown,

    // status
    output logic      line_sag_fault,
    output logic      line_sag_event_latch,
    output logic      supply_lockout,
    output logic      overtemperature_shutdown,
    output logic      timing_pin_open,
    output logic      startup_phase_latch
);

    localparam int unsigned CNT_W = (BLANK_CYCLES > WINDOW_CYCLES)
                                  ? $clog2(BLANK_CYCLES + 1)
                                  : $clog2(WINDOW_CYCLES + 1);

    localparam logic [CNT_W-1:0] BLANK_LAST  = CNT_W'(BLANK_CYCLES - 1);
    localparam logic [CNT_W-1:0] WINDOW_LAST = CNT_W'(WINDOW_CYCLES - 1);
    localparam logic [`TPIN_CNT_W-1:0] TPIN_LAST =
        `TPIN_CNT_W'(`TPIN_BLANK_CYCLES - 1);

    function automatic logic reached(input logic [CNT_W-1:0] cnt,
                                     input logic [CNT_W-1:0] last);
        reached = (cnt == last);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // flag synchronisation

    flag_sync_if #(.WIDTH(`FLAG_COUNT)) flags_bus ();

    assign flags_bus.raw[`FLAG_SAG_COMP]     = line_sag_comparator_out;
    assign flags_bus.raw[`FLAG_TIMING_LOW]   = timing_current_low;
    assign flags_bus.raw[`FLAG_UNDERVOLT]    = output_undervoltage_protect;
    assign flags_bus.raw[`FLAG_LATCH_OFF]    = latch_off_request;
    assign flags_bus.raw[`FLAG_TEMP_HOT]     = temp_above_upper;
    assign flags_bus.raw[`FLAG_TEMP_COOL]    = temp_below_lower;
    assign flags_bus.raw[`FLAG_SUPPLY_START] = supply_above_start;
    assign flags_bus.raw[`FLAG_SUPPLY_STOP]  = supply_below_stop;
    assign flags_bus.raw[`FLAG_REG_REACHED]  = regulation_reached;

    flag_sync #(.WIDTH(`FLAG_COUNT)) u_flag_sync
    (
        .clk   (clk),
        .nrst  (nrst),
        .flags (flags_bus)
    );

    flag_vec_t flag_s;
    logic      sag_s;
    logic      tlow_s;
    logic      undervolt_s;
    logic      latch_off_s;
    logic      hot_s;
    logic      cool_s;
    logic      start_s;
    logic      stop_s;
    logic      reg_s;

    assign flag_s      = flags_bus.synced;
    assign sag_s       = flag_s[`FLAG_SAG_COMP];
    assign tlow_s      = flag_s[`FLAG_TIMING_LOW];
    assign undervolt_s = flag_s[`FLAG_UNDERVOLT];
    assign latch_off_s = flag_s[`FLAG_LATCH_OFF];
    assign hot_s       = flag_s[`FLAG_TEMP_HOT];
    assign cool_s      = flag_s[`FLAG_TEMP_COOL];
    assign start_s     = flag_s[`FLAG_SUPPLY_START];
    assign stop_s      = flag_s[`FLAG_SUPPLY_STOP];
    assign reg_s       = flag_s[`FLAG_REG_REACHED];

    ////////////////////////////////////////////////////////////////////////////
    // supply lockout with 12 V / 10 V hysteresis

    logic lockout_q;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            lockout_q <= `LOCKOUT_RST;
        else if (stop_s)
            lockout_q <= 1'b1;
        else if (start_s)
            lockout_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // overtemperature shutdown with hysteresis

    // low means the upper threshold is being compared
    logic overtemp_q;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            overtemp_q <= `OVERTEMP_RST;
        else if (hot_s)
            overtemp_q <= 1'b1;
        else if (cool_s)
            overtemp_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // timing pin open detection

    logic [`TPIN_CNT_W-1:0] tpin_cnt_q;
    logic                   tpin_open_q;
    logic                   tpin_expired;

    // the counter holds at its last value while the flag stays high
    assign tpin_expired = tlow_s && (tpin_cnt_q == TPIN_LAST);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            tpin_cnt_q <= '0;
        else if (!tlow_s)
            tpin_cnt_q <= '0;
        else if (tpin_cnt_q != TPIN_LAST)
            tpin_cnt_q <= tpin_cnt_q + 1'b1;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            tpin_open_q <= `TPIN_OPEN_RST;
        else if (tpin_expired)
            tpin_open_q <= 1'b1;
        else if (lockout_q)
            tpin_open_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // line sag sequencer

    sag_state_t       state_q;
    sag_state_t       state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             event_latch_q;
    logic             event_latch_d;

    always_comb
    begin
        state_d       = state_q;
        cnt_d         = cnt_q;
        event_latch_d = event_latch_q;
        case (state_q)
            SAG_IDLE:
            begin
                cnt_d = '0;
                if (sag_s)
                begin
                    event_latch_d = 1'b1;
                    state_d       = SAG_BLANK;
                end
            end
            SAG_BLANK:
            begin
                // a fault is declared here only at the end of blanking, if the sag is still present
                if (reached(cnt_q, BLANK_LAST))
                begin
                    cnt_d = '0;
                    if (sag_s)
                    begin
                        state_d       = SAG_FAULT;
                        event_latch_d = 1'b0;
                    end
                    else
                    begin
                        state_d = SAG_WINDOW;
                    end
                end
                else
                begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            SAG_WINDOW:
            begin
                if (sag_s)
                begin
                    state_d       = SAG_FAULT;
                    cnt_d         = '0;
                    event_latch_d = 1'b0;
                end
                else if (reached(cnt_q, WINDOW_LAST))
                begin
                    state_d       = SAG_IDLE;
                    cnt_d         = '0;
                    event_latch_d = 1'b0;
                end
                else
                begin
                    cnt_d = cnt_q + 1'b1;
                end
            end
            SAG_FAULT:
            begin
                cnt_d         = '0;
                event_latch_d = 1'b0;
                // leave once powered and the pin is back above 1 V
                if (!lockout_q && !sag_s)
                    state_d = SAG_IDLE;
            end
            default:
            begin
                state_d       = SAG_FAULT;
                cnt_d         = '0;
                event_latch_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            state_q <= SAG_FAULT;
        else
            state_q <= state_d;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            cnt_q <= '0;
        else
            cnt_q <= cnt_d;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            event_latch_q <= 1'b0;
        else
            event_latch_q <= event_latch_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // off decision and start-up phase

    logic off_now;
    logic startup_q;

    assign off_now = lockout_q
                   | (state_q == SAG_FAULT)
                   | undervolt_s
                   | latch_off_s
                   | overtemp_q
                   | tpin_open_q;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            startup_q <= `STARTUP_RST;
        else if (off_now)
            startup_q <= 1'b1;
        else if (reg_s)
            startup_q <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs

    logic sag_fault_d;

    assign sag_fault_d = (state_d == SAG_FAULT);

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gate_drive_a_en     <= 1'b0;
            gate_drive_b_en     <= 1'b0;
            control_node_ground <= 1'b1;
            converter_ready     <= 1'b0;
        end
        else
        begin
            gate_drive_a_en     <= !off_now;
            gate_drive_b_en     <= !off_now;
            control_node_ground <= off_now;
            converter_ready     <= !off_now && !startup_q;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            hold_clamp_switch         <= 1'b0;
            hysteresis_current_source <= 1'b0;
            sense_pin_pulldown        <= 1'b1;
        end
        else
        begin
            hold_clamp_switch         <= sag_s && !sag_fault_d;
            hysteresis_current_source <= sag_fault_d && !lockout_q;
            sense_pin_pulldown        <= lockout_q;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            line_sag_fault           <= 1'b1;
            line_sag_event_latch     <= 1'b0;
            supply_lockout           <= `LOCKOUT_RST;
            overtemperature_shutdown <= `OVERTEMP_RST;
            timing_pin_open          <= `TPIN_OPEN_RST;
            startup_phase_latch      <= `STARTUP_RST;
        end
        else
        begin
            line_sag_fault           <= sag_fault_d;
            line_sag_event_latch     <= event_latch_d;
            supply_lockout           <= lockout_q;
            overtemperature_shutdown <= overtemp_q;
            timing_pin_open          <= tpin_open_q;
            startup_phase_latch      <= startup_q;
        end
    end

endmodule

// ### verif/brownout_fault_sequencer_chk.sv
`timescale 1ns/10ps
`include "brownout_defines.svh"
module brownout_fault_sequencer_chk
#(
    parameter int unsigned BLANK_CYCLES  = 40,
    parameter int unsigned WINDOW_CYCLES = 10
)
(
    // watched ports
    input wire logic clk,
    input wire logic nrst,
    input wire logic line_sag_comparator_out,
    input wire logic timing_current_low,
    input wire logic gate_drive_a_en,
    input wire logic gate_drive_b_en,
    input wire logic control_node_ground,
    input wire logic converter_ready,
    input wire logic hold_clamp_switch,
    input wire logic hysteresis_current_source,
    input wire logic line_sag_fault,
    input wire logic line_sag_event_latch,
    input wire logic supply_lockout,
    input wire logic overtemperature_shutdown,
    input wire logic timing_pin_open
);
    int   latch_cnt_q;
    int   low_cnt_q;
    logic off_src;

    assign off_src = supply_lockout | overtemperature_shutdown | timing_pin_open;

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    ////////////////////////////////////////////////////////////////////////////
    // cycles the event latch has stood outside a fault
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            latch_cnt_q <= 0;
        else
            latch_cnt_q <= (line_sag_event_latch && !line_sag_fault) ? latch_cnt_q + 1 : 0;
    end

    // consecutive cycles of low timing current
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            low_cnt_q <= 0;
        else
            low_cnt_q <= timing_current_low ? low_cnt_q + 1 : 0;
    end

    ////////////////////////////////////////////////////////////////////////////
    chk_drive_pair: assert property (gate_drive_a_en == gate_drive_b_en)
        else $error("gate enables differ");
    chk_off_sinks: assert property (off_src && $past(off_src) |-> !gate_drive_a_en)
        else $error("drive on while off");
    chk_sag_outputs: assert property (line_sag_fault[*3] |-> !gate_drive_a_en
        && control_node_ground && !converter_ready)
        else $error("sag fault outputs wrong");
    chk_sag_pin: assert property ((line_sag_fault && !supply_lockout)[*3]
        |-> hysteresis_current_source && !hold_clamp_switch)
        else $error("sense pin controls wrong in fault");
    chk_clamp_close: assert property ($rose(line_sag_comparator_out)
        && !line_sag_event_latch && !line_sag_fault |-> ##[2:4] hold_clamp_switch)
        else $error("clamp not closed");
    chk_blank_span: assert property ($rose(line_sag_fault)
        && $past(line_sag_event_latch) |-> $past(latch_cnt_q) >= BLANK_CYCLES - 2)
        else $error("fault before blanking end");
    chk_latch_span: assert property (latch_cnt_q <= BLANK_CYCLES + WINDOW_CYCLES + 2)
        else $error("event latch not cleared");
    chk_pin_blank: assert property ($rose(timing_pin_open)
        |-> low_cnt_q >= `TPIN_BLANK_CYCLES)
        else $error("open latch set too early");
    chk_pin_set: assert property (low_cnt_q >= `TPIN_BLANK_CYCLES + 3
        |-> timing_pin_open)
        else $error("open latch not set");
endmodule

bind brownout_fault_sequencer brownout_fault_sequencer_chk
    #(.BLANK_CYCLES(BLANK_CYCLES), .WINDOW_CYCLES(WINDOW_CYCLES)) chk_u (.*);

// ### verif/line_front_end_model.sv
`timescale 1ns/10ps
module line_front_end_model
(
    // analog levels
    input int         line_mv,
    input int         vcc_mv,
    input int         temp_c,
    input int         rt_na,
    input int         sd_mv,
    // sense pin controls
    input wire logic  hold_clamp_switch,
    input wire logic  hysteresis_current_source,
    input wire logic  sense_pin_pulldown,
    // comparator flags
    output logic      line_sag_comparator_out,
    output logic      supply_above_start,
    output logic      supply_below_stop,
    output logic      temp_above_upper,
    output logic      temp_below_lower,
    output logic      timing_current_low,
    output logic      latch_off_request
);
    int sense_mv;

    // pin level from divider, 200 mV drop from the hysteresis source
    always_comb
    begin
        sense_mv = hysteresis_current_source ? line_mv - 200 : line_mv;
        if (hold_clamp_switch && sense_mv < 980)
            sense_mv = 980;
        if (sense_pin_pulldown)
            sense_mv = 0;
    end

    assign line_sag_comparator_out = sense_mv < 1000;
    assign supply_above_start = vcc_mv > 12000;
    assign supply_below_stop = vcc_mv < 10000;
    assign temp_above_upper = temp_c > 140;
    assign temp_below_lower = temp_c < 80;
    assign timing_current_low = rt_na < 7000;
    assign latch_off_request = sd_mv > 166;
endmodule

// ### verif/brownout_fault_sequencer_bench.sv
`timescale 1ns/10ps
module brownout_fault_sequencer_bench;
    localparam int BLK = 40;
    localparam int WIN = 10;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic out_uv = 1'b0;
    logic reg_ok = 1'b0;
    int   line_mv = 1500;
    int   vcc_mv = 0;
    int   temp_c = 25;
    int   rt_na = 20000;
    int   sd_mv = 0;
    int   error_cnt = 0;
    int   samples_checked = 0;
    logic line_sag_comparator_out, supply_above_start, supply_below_stop;
    logic temp_above_upper, temp_below_lower, timing_current_low, latch_off_request;
    logic hold_clamp_switch, hysteresis_current_source, sense_pin_pulldown;
    logic ga, gb, gnd, rdy, fault, ev, lock, ots, topen, stup;

    always #4 clk = ~clk;

    line_front_end_model front_u (.line_mv, .vcc_mv, .temp_c, .rt_na, .sd_mv,
        .hold_clamp_switch, .hysteresis_current_source, .sense_pin_pulldown,
        .line_sag_comparator_out, .supply_above_start, .supply_below_stop,
        .temp_above_upper, .temp_below_lower, .timing_current_low, .latch_off_request);

    brownout_fault_sequencer #(.BLANK_CYCLES(BLK), .WINDOW_CYCLES(WIN)) dut_u (.clk, .nrst,
        .line_sag_comparator_out, .timing_current_low, .output_undervoltage_protect(out_uv),
        .latch_off_request, .temp_above_upper, .temp_below_lower, .supply_above_start,
        .supply_below_stop, .regulation_reached(reg_ok), .gate_drive_a_en(ga),
        .gate_drive_b_en(gb), .control_node_ground(gnd), .converter_ready(rdy),
        .hold_clamp_switch, .hysteresis_current_source, .sense_pin_pulldown,
        .line_sag_fault(fault), .line_sag_event_latch(ev), .supply_lockout(lock),
        .overtemperature_shutdown(ots), .timing_pin_open(topen), .startup_phase_latch(stup));

    ////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic look;
        @(negedge clk);
    endtask

    task automatic cmp(input logic act, input logic exp, input string what);
        samples_checked++;
        if (act !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask

    task automatic conclude;
        if (error_cnt == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_power_up;
        tick(1);
        vcc_mv <= 11000;
        tick(10);
        look;
        cmp(lock, 1'b1, "lockout");
        cmp(fault, 1'b1, "start fault");
        cmp(sense_pin_pulldown, 1'b1, "pin held low");
        tick(1);
        vcc_mv <= 12500;
        tick(12);
        look;
        cmp(lock, 1'b0, "release");
        cmp(ga, 1'b1, "drive");
        cmp(gb, 1'b1, "drive b");
        cmp(sense_pin_pulldown, 1'b0, "pin released");
        cmp(rdy, 1'b0, "ready in start-up");
        cmp(stup, 1'b1, "start-up phase");
        tick(1);
        reg_ok <= 1'b1;
        tick(6);
        look;
        cmp(rdy, 1'b1, "ready");
        cmp(stup, 1'b0, "start-up over");
    endtask

    task automatic t_short_dropout;
        logic drop = 1'b0;
        logic saw_clamp = 1'b0;
        logic saw_ev = 1'b0;
        tick(1);
        line_mv <= 500;
        tick(1);
        line_mv <= 1500;
        repeat (BLK + WIN + 10)
        begin
            look;
            drop |= !rdy;
            saw_clamp |= hold_clamp_switch;
            saw_ev |= ev;
        end
        cmp(drop, 1'b0, "ready held");
        cmp(saw_clamp, 1'b1, "clamp");
        cmp(saw_ev, 1'b1, "event");
        cmp(ev, 1'b0, "event cleared");
        cmp(fault, 1'b0, "no fault");
    endtask

    task automatic t_long_sag;
        tick(1);
        line_mv <= 500;
        tick(BLK / 2);
        look;
        cmp(fault, 1'b0, "early fault");
        tick(BLK / 2 + 8);
        look;
        cmp(fault, 1'b1, "fault");
        cmp(gnd, 1'b1, "ground");
        cmp(gb, 1'b0, "drive b off");
        cmp(hysteresis_current_source, 1'b1, "hysteresis");
        tick(1);
        line_mv <= 1100;
        tick(20);
        look;
        cmp(fault, 1'b1, "fault held");
        tick(1);
        line_mv <= 1500;
        tick(10);
        look;
        cmp(hysteresis_current_source, 1'b0, "hysteresis off");
        cmp(ga, 1'b1, "resume");
    endtask

    task automatic t_window_hit;
        tick(1);
        line_mv <= 500;
        tick(1);
        line_mv <= 1500;
        tick(BLK + 5);
        line_mv <= 500;
        tick(3);
        line_mv <= 1100;
        tick(4);
        look;
        cmp(fault, 1'b1, "window fault");
        cmp(rdy, 1'b0, "window ready");
        tick(1);
        line_mv <= 1500;
        tick(12);
    endtask

    task automatic t_faults;
        for (int k = 0; k < 2; k++)
        begin
            tick(1);
            sd_mv <= (k == 0) ? 200 : 150;
            out_uv <= (k == 1);
            tick(6);
            look;
            cmp(rdy, 1'b0, "fault ready");
            tick(1);
            sd_mv <= 150;
            out_uv <= 1'b0;
            tick(8);
            look;
            cmp(rdy, 1'b1, "fault cleared");
        end
        tick(1);
        temp_c <= 150;
        tick(6);
        temp_c <= 100;
        tick(6);
        look;
        cmp(ots, 1'b1, "hot held");
        tick(1);
        nrst <= 1'b0;
        tick(3);
        nrst <= 1'b1;
        tick(30);
        look;
        cmp(ots, 1'b0, "upper level");
    endtask

    task automatic t_timing_pin;
        tick(1);
        rt_na <= 5000;
        tick(3700);
        rt_na <= 20000;
        tick(6);
        look;
        cmp(topen, 1'b0, "short dip");
        tick(1);
        rt_na <= 5000;
        tick(3800);
        rt_na <= 20000;
        vcc_mv <= 11000;
        tick(10);
        look;
        cmp(topen, 1'b1, "open held");
        cmp(ga, 1'b0, "open drive");
        cmp(lock, 1'b0, "above stop");
        tick(1);
        vcc_mv <= 9500;
        tick(10);
        look;
        cmp(topen, 1'b0, "open cleared");
        tick(1);
        vcc_mv <= 12500;
        tick(150);
        look;
        cmp(ga, 1'b1, "resume");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        tick(3);
        nrst <= 1'b1;
        look;
        cmp(fault, 1'b1, "reset fault");
        cmp(ga, 1'b0, "reset drive");
        cmp(ots, 1'b0, "reset temperature");
        t_power_up;
        t_short_dropout;
        t_long_sag;
        t_window_hit;
        t_faults;
        t_timing_pin;
        conclude;
    end

    initial
    begin
        tick(20000);
        error_cnt++;
        conclude;
    end
endmodule
